// >>> logic/irdc_pkg.sv
// Purpose: Shared constants and types for the filter and result routing block.
// Assumes: 32-bit AXI4-Lite register access, 14-bit results.
// Notes:   Offsets are byte addresses.
package irdc_pkg;
	localparam int          IRDC_RES_W      = 14;
	localparam int          IRDC_FRAC_W     = 3;
	localparam int          IRDC_ACC_W      = IRDC_RES_W + IRDC_FRAC_W;
	localparam int          IRDC_NCH        = 15;
	localparam logic [7:0]  IRDC_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  IRDC_OFF_ENABLE = 8'h04;
	localparam logic [7:0]  IRDC_OFF_STATUS = 8'h08;
	localparam logic [7:0]  IRDC_OFF_SEL    = 8'h0c;
	localparam logic [7:0]  IRDC_OFF_RESULT = 8'h10;
	localparam logic [7:0]  IRDC_OFF_FILT   = 8'h14;
	localparam logic [7:0]  IRDC_OFF_SUM    = 8'h18;
	localparam int          IRDC_B_CAL      = 0;
	localparam int          IRDC_B_UPD      = 1;
	localparam int          IRDC_B_RDF      = 2;
	localparam int          IRDC_B_DBL      = 3;
	localparam int          IRDC_B_ALS      = 4;
	localparam int          IRDC_B_SINIT    = 5;
	localparam int          IRDC_B_BINIT    = 6;
	localparam int          IRDC_B_FC       = 8;
	localparam logic [2:0]  IRDC_FC_RESET   = 3'h2;
	localparam logic [2:0]  IRDC_FC_OFF     = 3'h7;
	localparam logic [2:0]  IRDC_FC_MIN     = 3'h0;
	localparam logic [31:0] IRDC_CTRL_RESET = 32'h0000_0206;
	localparam logic [14:0] IRDC_EN_RESET   = 15'h7fff;
	localparam logic [1:0]  IRDC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  IRDC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        valid;
		logic [3:0]  chan;
		logic [13:0] raw;
		logic [13:0] cal;
		logic        balance;
	} irdc_sample_type;

	typedef struct packed {
		logic scan_end;
		logic next_start;
		logic data_move;
	} irdc_event_type;
endpackage

// >>> logic/irdc_top.sv
// Operation
// - Calibration enable picks corrected or raw sample.
// - Only enabled channels are filtered.
// - Sum has no filter, uses selected data.
// - Balancing always filters; code 111 forced 000.
// - Output is fc*new plus (1-fc)*old.
// - Coefficient code resets to 3/8.
// - Codes step coefficient by one eighth.
// - Code 111 passes the newest sample.
// - At 1/8 step settles in 33/44 samples.
// - Update disabled keeps filter history.
// - Update enabled folds sample at the load event.
// - Read select picks filtered or raw results.
// - Single buffer loads filter at scan end.
// - Double buffer loads at next sequence start.
// - No request: load in move if not ready.
// - Alert source 0 uses raw data.
// - Alert source 1 uses filtered data.
// - Diagnostics always use unfiltered data.
// - No init request keeps accumulator contents.
// - Init request loads next sample directly.
// - Init reloads to first new measurement.
// - Out-of-scan move copies selected data set.
// Purpose: Per-channel IIR filter and result routing with AXI4-Lite registers.
// Assumes: Samples and sequence events come from logic on i_clk.
// Notes:   One sample per cycle at most; loads happen on the selected event.
`timescale 1ns/100ps
module irdc_top
	import irdc_pkg::*;
#(
	parameter int NCH = IRDC_NCH
) (
	input  wire logic            i_clk,
	input  wire logic            i_resetn,
	input  wire irdc_sample_type i_sample,
	input  wire irdc_event_type  i_event,
	input  wire logic            i_acq_request,
	input  wire logic            i_ready_flag,
	input  wire logic [31:0]     i_awaddr,
	input  wire logic            i_awvalid,
	output logic                 o_awready,
	input  wire logic [31:0]     i_wdata,
	input  wire logic [3:0]      i_wstrb,
	input  wire logic            i_wvalid,
	output logic                 o_wready,
	output logic [1:0]           o_bresp,
	output logic                 o_bvalid,
	input  wire logic            i_bready,
	input  wire logic [31:0]     i_araddr,
	input  wire logic            i_arvalid,
	output logic                 o_arready,
	output logic [31:0]          o_rdata,
	output logic [1:0]           o_rresp,
	output logic                 o_rvalid,
	input  wire logic            i_rready,
	output logic [13:0]          o_alert_data,
	output logic [3:0]           o_alert_chan,
	output logic                 o_alert_valid,
	output logic [13:0]          o_diag_data,
	output logic                 o_diag_valid
);
	// ****************************************
	// Registers and storage
	// ****************************************
	logic [31:0]           ctrl;
	logic [NCH-1:0]        enable;
	logic [3:0]            sel_chan;
	logic [IRDC_ACC_W-1:0] acc     [NCH];
	logic [13:0]           alu     [NCH];
	logic [13:0]           result  [NCH];
	logic [NCH-1:0]        init_pend;
	logic [NCH-1:0]        loaded;
	logic [17:0]           cell_sum;
	logic                  aw_held;
	logic                  w_held;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;

	logic [2:0] fc_user;
	logic [2:0] fc_bal;
	logic       upd_en;
	logic       rd_filt;
	logic       dbl_buf;
	logic       alert_sel;
	logic       load_now;
	logic       move_now;
	logic [13:0] sample_in;

	assign fc_user   = ctrl[IRDC_B_FC +: 3];
	assign upd_en    = ctrl[IRDC_B_UPD];
	assign rd_filt   = ctrl[IRDC_B_RDF];
	assign dbl_buf   = ctrl[IRDC_B_DBL];
	assign alert_sel = ctrl[IRDC_B_ALS];
	assign fc_bal    = (fc_user == IRDC_FC_OFF) ? IRDC_FC_MIN : fc_user;

	// Corrected sample when calibration applies, raw otherwise.
	assign sample_in = ctrl[IRDC_B_CAL] ? i_sample.cal : i_sample.raw;

	// Filter load instant depends on buffer mode and request.
	always_comb begin
		load_now = 1'b0;
		if (i_acq_request && !dbl_buf) begin
			load_now = i_event.scan_end;
		end else if (i_acq_request && dbl_buf) begin
			load_now = i_event.next_start;
		end else begin
			load_now = i_event.data_move && !i_ready_flag;
		end
	end
	assign move_now = i_event.data_move && !i_ready_flag && !i_acq_request;

	// ****************************************
	// Filter arithmetic
	// ****************************************
	// Eighth-step weights keep three fraction bits so no resolution is lost.
	function automatic logic [IRDC_ACC_W-1:0] irdc_iir(
		input logic [IRDC_ACC_W-1:0] old_v,
		input logic [13:0]           x,
		input logic [2:0]            code
	);
		logic [20:0] num;
		logic [3:0]  w;
		w   = {1'b0, code} + 4'h1;
		num = 21'(w) * 21'({x, 3'h0}) + 21'(4'h8 - w) * 21'(old_v);
		return IRDC_ACC_W'(num >> 3);
	endfunction

	// ****************************************
	// Control register and per-channel state
	// ****************************************
	logic wr_go;
	logic sel_ok;
	assign wr_go = aw_held && w_held && !o_bvalid;
	// A select past the last channel reads as zero rather than unknown.
	assign sel_ok = 32'(sel_chan) < NCH;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl     <= IRDC_CTRL_RESET;
			enable   <= IRDC_EN_RESET;
			sel_chan <= 4'h0;
		end else if (wr_go) begin
			case (aw_addr)
				IRDC_OFF_CTRL: begin
					if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
					if (w_strb[1]) ctrl[10:8] <= w_data[10:8];
				end
				IRDC_OFF_ENABLE: begin
					if (w_strb[0]) enable[7:0] <= w_data[7:0];
					if (w_strb[1]) enable[NCH-1:8] <= w_data[NCH-1:8];
				end
				IRDC_OFF_SEL: begin
					if (w_strb[0]) sel_chan <= w_data[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Current-scan ALU values, one per channel.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < NCH; i++) alu[i] <= 14'h0000;
		end else if (i_sample.valid && (32'(i_sample.chan) < NCH)) begin
			alu[i_sample.chan] <= sample_in;
		end
	end

	// Init requests arm every channel; the first load then replaces history.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			init_pend <= '0;
		end else if (wr_go && aw_addr == IRDC_OFF_CTRL && w_strb[0]
			&& (w_data[IRDC_B_SINIT] || w_data[IRDC_B_BINIT])) begin
			init_pend <= '1;
		end else if (load_now && (upd_en || i_sample.balance)) begin
			init_pend <= init_pend & ~enable;
		end
	end

	// Accumulators: gated by update enable (bypassed by a balance sample) and channel enable.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < NCH; i++) acc[i] <= '0;
			loaded <= '0;
		end else if (load_now && (upd_en || i_sample.balance)) begin
			for (int i = 0; i < NCH; i++) begin
				if (enable[i]) begin
					if (init_pend[i] || (ctrl[IRDC_B_SINIT] && !loaded[i])) begin
						acc[i] <= {alu[i], 3'h0};
					end else if (i_sample.balance) begin
						acc[i] <= irdc_iir(acc[i], alu[i], fc_bal);
					end else begin
						acc[i] <= irdc_iir(acc[i], alu[i], fc_user);
					end
					loaded[i] <= 1'b1;
				end
			end
		end
	end

	// Result registers take filtered or raw values on a filter load or a move.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < NCH; i++) result[i] <= 14'h0000;
		end else if (load_now || move_now) begin
			for (int i = 0; i < NCH; i++) begin
				if (enable[i]) begin
					result[i] <= rd_filt ? acc[i][IRDC_ACC_W-1 -: 14] : alu[i];
				end
			end
		end
	end

	// Sum over cell channels of the selected data; block channel excluded.
	logic [17:0] next_cell_sum;

	always_comb begin
		next_cell_sum = 18'h00000;
		for (int i = 0; i < NCH - 1; i++) begin
			if (enable[i]) begin
				next_cell_sum = next_cell_sum
					+ 18'(alert_sel ? acc[i][IRDC_ACC_W-1 -: 14] : alu[i]);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cell_sum <= 18'h00000;
		end else begin
			cell_sum <= next_cell_sum;
		end
	end

	// ****************************************
	// Alert and diagnostic outputs
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_alert_data  <= 14'h0000;
			o_alert_chan  <= 4'h0;
			o_alert_valid <= 1'b0;
			o_diag_data   <= 14'h0000;
			o_diag_valid  <= 1'b0;
		end else begin
			o_alert_valid <= i_sample.valid;
			o_alert_chan  <= i_sample.chan;
			if (alert_sel && (32'(i_sample.chan) < NCH)) begin
				o_alert_data <= acc[i_sample.chan][IRDC_ACC_W-1 -: 14];
			end else begin
				o_alert_data <= sample_in;
			end
			o_diag_valid <= i_sample.valid;
			o_diag_data  <= sample_in;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0000_0000;
			w_strb    <= 4'h0;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= IRDC_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held   <= 1'b1;
				aw_addr   <= i_awaddr[7:0];
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held   <= 1'b1;
				w_data   <= i_wdata;
				w_strb   <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (wr_go) begin
				o_bvalid <= 1'b1;
				o_bresp  <= (aw_addr == IRDC_OFF_CTRL || aw_addr == IRDC_OFF_ENABLE
					|| aw_addr == IRDC_OFF_SEL) ? IRDC_RESP_OKAY : IRDC_RESP_SLVERR;
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= IRDC_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rresp   <= IRDC_RESP_OKAY;
			case (i_araddr[7:0])
				IRDC_OFF_CTRL:   o_rdata <= {21'h0, ctrl[10:8], 1'b0, ctrl[6:0]};
				IRDC_OFF_ENABLE: o_rdata <= 32'(enable);
				IRDC_OFF_STATUS: o_rdata <= 32'({init_pend, loaded});
				IRDC_OFF_SEL:    o_rdata <= 32'(sel_chan);
				IRDC_OFF_RESULT: o_rdata <= sel_ok ? 32'(result[sel_chan]) : 32'h0000_0000;
				IRDC_OFF_FILT:   o_rdata <= sel_ok ? 32'(acc[sel_chan]) : 32'h0000_0000;
				IRDC_OFF_SUM:    o_rdata <= 32'(cell_sum);
				default: begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= IRDC_RESP_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// Load events that must leave the history untouched in their mode.
	sequence dbl_scan_end_s;
		i_acq_request && dbl_buf && i_event.scan_end && !i_event.next_start;
	endsequence

	sequence ready_move_s;
		!i_acq_request && i_ready_flag && i_event.data_move;
	endsequence

	hold_when_off_a: assert property (load_now && !upd_en && !i_sample.balance
		|=> acc[0] == $past(acc[0])) else $error("history changed while update off");
	bypass_code_a: assert property (load_now && upd_en && !i_sample.balance
		&& fc_user == IRDC_FC_OFF && enable[0] && !init_pend[0] && loaded[0]
		|=> acc[0][16:3] == $past(alu[0])) else $error("code 7 did not pass sample");
	bal_force_a: assert property (load_now && i_sample.balance && fc_user == IRDC_FC_OFF
		&& enable[0] && !init_pend[0] && loaded[0]
		|=> 20'(acc[0]) == ((20'({$past(alu[0]), 3'h0}) + 20'h7 * 20'($past(acc[0]))) >> 3))
		else $error("balance code not forced");
	diag_raw_a: assert property (i_sample.valid |=> o_diag_data == $past(sample_in))
		else $error("diag not unfiltered");
	alert_raw_a: assert property (!alert_sel && i_sample.valid
		|=> o_alert_data == $past(sample_in)) else $error("alert not raw");
	init_load_a: assert property (load_now && upd_en && enable[0] && init_pend[0]
		|=> acc[0] == {$past(alu[0]), 3'h0}) else $error("init not direct load");
	disabled_chan_a: assert property (!enable[0] |=> $stable(acc[0]))
		else $error("disabled channel filtered");
	result_sel_a: assert property (move_now && rd_filt && enable[0]
		|=> result[0] == $past(acc[0][16:3])) else $error("move used wrong source");
	raw_result_a: assert property (load_now && !rd_filt && enable[0]
		|=> result[0] == $past(alu[0])) else $error("raw result not routed");
	filt_alert_a: assert property (alert_sel && i_sample.valid && i_sample.chan == 4'h0
		|=> o_alert_data == $past(acc[0][16:3])) else $error("alert not filtered");
	dbl_defer_a: assert property (dbl_scan_end_s |=> $stable(acc[0]))
		else $error("double buffer loaded at scan end");
	ready_skip_a: assert property (ready_move_s |=> $stable(acc[0]))
		else $error("move loaded while results ready");
endmodule

// >>> verification/irdc_seq_model.sv
// Purpose: Sequencer stand-in that offers channel samples and load events.
// Assumes: Tasks are entered right after a rising edge of i_clk.
// Notes:   Payload is scrambled while no sample is offered.
`timescale 1ns/100ps
module irdc_seq_model
	import irdc_pkg::*;
(
	input  wire logic       i_clk,
	output irdc_sample_type o_sample,
	output irdc_event_type  o_event
);
	initial begin
		o_sample = '0;
		o_event  = '0;
	end

	// Offers one sample on channel 0 for exactly one cycle.
	task automatic send(input logic [13:0] r, input logic [13:0] c, input logic b);
		o_sample <= '{1'b1, 4'h0, r, c, b};
		@(posedge i_clk);
		o_sample <= '{1'b0, 4'hf, ~r, ~c, b};
	endtask

	// Kind 0 is scan end, 1 next sequence start, 2 data move.
	task automatic pulse(input int k);
		@(posedge i_clk);
		o_event <= irdc_event_type'(3'h4 >> k);
		@(posedge i_clk);
		o_event <= '0;
	endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the filter and result routing block.
// Assumes: Every sample is sent on channel 0; filter and results are read over the register bus, alert and diag data at the ports.
// Notes:   The reference filter is kept as integers in the bench.
`timescale 1ns/100ps
module tb_top
	import irdc_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic            i_clk = 1'b0;
	logic            i_resetn = 1'b0;
	logic            i_acq_request = 1'b1;
	logic            i_ready_flag = 1'b0;
	logic [31:0]     i_awaddr = '0, i_wdata = '0, i_araddr = '0;
	logic [3:0]      i_wstrb = 4'hf;
	logic            i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic            i_arvalid = 1'b0, i_rready = 1'b0;
	logic            o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic            o_alert_valid, o_diag_valid;
	logic [1:0]      o_bresp, o_rresp, rr;
	logic [31:0]     o_rdata, rv;
	logic [13:0]     o_alert_data, o_diag_data;
	logic [3:0]      o_alert_chan;
	irdc_sample_type smp;
	irdc_event_type  evt;
	int              fail_count = 0, samples_checked = 0;
	int              acc = 0, code = 2, rdf = 1, cal = 0, x, c;

	always #2.5 i_clk = ~i_clk;

	irdc_seq_model m (.i_clk(i_clk), .o_sample(smp), .o_event(evt));

	irdc_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sample(smp), .i_event(evt),
		.i_acq_request(i_acq_request), .i_ready_flag(i_ready_flag),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_alert_data(o_alert_data), .o_alert_chan(o_alert_chan),
		.o_alert_valid(o_alert_valid), .o_diag_data(o_diag_data),
		.o_diag_valid(o_diag_valid));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 50) begin
			fail_count++;
			$display("mismatch at %0t: bus answer timed out", $time);
			report_and_stop();
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge i_clk);
		i_awaddr <= {24'h0, a};
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_clk);
			if (i_awvalid && o_awready) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		tmo(n);
		r = o_bresp;
		i_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge i_clk);
		i_araddr <= {24'h0, a};
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_clk);
			if (i_arvalid && o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		tmo(n);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		axr(a, rv, rr);
		chk(rv, e);
		chk(rr, IRDC_RESP_OKAY);
	endtask

	task automatic wc(input logic [31:0] v);
		axw(IRDC_OFF_CTRL, v, rr);
		code = v[10:8];
		rdf = v[2];
		cal = v[0];
	endtask

	function automatic int filt(int a, int xv, int cc);
		return ((cc + 1) * xv * 8 + (7 - cc) * a) / 8;
	endfunction

	// Sends one sample, fires one event and compares accumulator, and result when a load is expected.
	task automatic run(input int k, input bit b, input bit ld, input bit ini);
		int cc;
		int old;
		x = $urandom % 16384;
		c = $urandom % 16384;
		cc = (b && code == 7) ? 0 : code;
		old = acc;
		@(posedge i_clk);
		m.send(x[13:0], c[13:0], b);
		m.pulse(k);
		if (ld) acc = ini ? x * 8 : filt(acc, x, cc);
		rdc(IRDC_OFF_FILT, acc);
		if (ld) rdc(IRDC_OFF_RESULT, rdf ? old / 8 : x);
	endtask

	task automatic ad(input int cl, input int al);
		wc(32'h0000_0200 | cl | (al << 4));
		x = $urandom % 16384;
		c = $urandom % 16384;
		@(posedge i_clk);
		m.send(x[13:0], c[13:0], 1'b0);
		#1;
		chk(o_diag_data, cl ? c : x);
		chk(o_alert_data, al ? acc / 8 : (cl ? c : x));
		chk({o_alert_valid, o_diag_valid, o_alert_chan}, 6'h30);
		rdc(IRDC_OFF_SUM, al ? acc / 8 : (cl ? c : x));
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		void'($urandom(15050));
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		rdc(IRDC_OFF_CTRL, IRDC_CTRL_RESET);
		rdc(IRDC_OFF_ENABLE, {17'h0, IRDC_EN_RESET});
		rdc(IRDC_OFF_FILT, 32'h0);
		axr(8'h1c, rv, rr);
		chk(rr, IRDC_RESP_SLVERR);
		chk(rv, 32'h0);
		axw(IRDC_OFF_STATUS, 32'h1, rr);
		chk(rr, IRDC_RESP_SLVERR);
		axw(IRDC_OFF_SEL, 32'h0, rr);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			wc(32'h2 | (k << 8));
			run(0, 1'b0, 1'b1, 1'b0);
		end
		$display("test coefficients done");
		wc(32'h200);
		run(0, 1'b0, 1'b0, 1'b0);
		wc(32'h206);
		run(0, 1'b0, 1'b1, 1'b0);
		axw(IRDC_OFF_ENABLE, 32'h7ffe, rr);
		run(0, 1'b0, 1'b0, 1'b0);
		axw(IRDC_OFF_ENABLE, 32'h7fff, rr);
		$display("test update and enable done");
		wc(32'h20e);
		run(0, 1'b0, 1'b0, 1'b0);
		run(1, 1'b0, 1'b1, 1'b0);
		i_acq_request <= 1'b0;
		i_ready_flag <= 1'b1;
		run(2, 1'b0, 1'b0, 1'b0);
		i_ready_flag <= 1'b0;
		run(2, 1'b0, 1'b1, 1'b0);
		$display("test load timing done");
		wc(32'h700);
		i_acq_request <= 1'b1;
		run(0, 1'b1, 1'b1, 1'b0);
		wc(32'h226);
		rdc(IRDC_OFF_STATUS, 32'h3fff_ffff);
		run(0, 1'b0, 1'b1, 1'b1);
		run(0, 1'b0, 1'b1, 1'b0);
		wc(32'h246);
		run(0, 1'b1, 1'b1, 1'b1);
		$display("test balance and init done");
		for (int i = 0; i < 4; i++) begin
			ad(i % 2, i / 2);
		end
		$display("test routing done");
		i_resetn <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		acc = 0;
		rdc(IRDC_OFF_FILT, 32'h0);
		rdc(IRDC_OFF_CTRL, IRDC_CTRL_RESET);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
